// >>> tb/fpm_fan_model.sv
// Behavioural cooling fan on the drive output: it only measures the drive waveform.
// Assumes the drive is active high and sampled on the rising edge of sys_clk.
`timescale 1ns/1ns
`default_nettype none
module fpm_fan_model (
	// Clock
	input wire logic sys_clk,
	// Fan drive
	input wire logic pwm_in,
	// Last measured period and high time in sys_clk cycles
	output var int period,
	output var int high
);
	logic prev = 1'b0;
	int cnt = 0;
	// A fan draws no current back, so measuring edges is all it does here.
	always @(posedge sys_clk) begin
		prev <= pwm_in;
		if (pwm_in && !prev) begin
			period <= cnt;
			cnt <= 1;
		end else begin
			cnt <= cnt + 1;
		end
		if (!pwm_in && prev) begin
			high <= cnt;
		end
	end
endmodule : fpm_fan_model
`default_nettype wire

// >>> tb/tb_top.sv
// Self-checking bench for the fan duty and frequency block.
// Assumes short master tick counts of 10 and 20 system cycles.
`timescale 1ns/1ns
`default_nettype none
module tb_top;
	localparam int N = 12;
	logic sys_clk = 1'b0;
	logic nrst = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic reg_wr = 1'b0;
	logic [7:0] reg_wdata = 8'h00;
	logic [7:0] reg_rdata;
	logic manual_override = 1'b0;
	logic clk_select = 1'b1;
	logic spinup_active = 1'b0;
	logic [7:0] remote_temp = 8'h00;
	logic [N*7-1:0] thr_flat;
	logic [N*6-1:0] duty_flat;
	logic fan_pwm;
	int period;
	int high;
	int bad_count = 0;
	int n_compared = 0;
	always #2 sys_clk = ~sys_clk;
	fpm_top #(.N(N), .FAST_DIV(10), .SLOW_DIV(20)) dut (.sys_clk(sys_clk), .nrst(nrst),
		.reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.manual_override(manual_override), .clk_select(clk_select),
		.spinup_active(spinup_active), .remote_temp(remote_temp), .thr_flat(thr_flat),
		.duty_flat(duty_flat), .fan_pwm(fan_pwm));
	fpm_fan_model fan (.sys_clk(sys_clk), .pwm_in(fan_pwm), .period(period), .high(high));
	////////////////////////////////////////////////////////////////////////////
	task automatic summarize;
		$display("compared %0d mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : summarize
	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			bad_count++;
			$display("MISMATCH %s expected %h seen %h", name, exp, seen);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(negedge sys_clk);
		reg_wr = 1'b0;
	endtask : wr
	// The read data is registered, so it is looked at two falling edges after the address.
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		reg_addr = a;
		@(negedge sys_clk);
		@(negedge sys_clk);
		chk("reg_rdata", reg_rdata, exp);
	endtask : rd
	task automatic set_temp(input logic [7:0] t);
		remote_temp = t;
		repeat (3) @(negedge sys_clk);
	endtask : set_temp
	// Old period must run out before a new divisor shows, so the wait covers it.
	task automatic fan_case(input logic [4:0] n, input logic sel);
		int ticks;
		int div;
		ticks = 2 * ((n == 5'h00) ? 1 : n);
		div = sel ? 10 : 20;
		clk_select = sel;
		wr(fpm_pkg::ADDR_FREQ, {3'h0, n});
		repeat (1000 + 3 * ticks * div) @(negedge sys_clk);
		chk("fan_period", period, ticks * div);
		chk("fan_high", high, (32 * ticks / 64) * div);
	endtask : fan_case
	////////////////////////////////////////////////////////////////////////////
	initial begin
		for (int i = 0; i < N; i++) begin
			thr_flat[i*7+:7] = 7'(20 + 5 * i);
			duty_flat[i*6+:6] = 6'(4 * i + 3);
		end
		repeat (8) @(negedge sys_clk);
		nrst = 1'b1;
		rd(fpm_pkg::ADDR_DUTY, 8'h00);
		rd(fpm_pkg::ADDR_FREQ, 8'h17);
		rd(fpm_pkg::ADDR_OFFS, 8'h00);
		rd(fpm_pkg::ADDR_HYST, 8'h04);
		rd(8'h50, 8'h00);
		wr(fpm_pkg::ADDR_FREQ, 8'hFF);
		rd(fpm_pkg::ADDR_FREQ, 8'h1F);
		wr(fpm_pkg::ADDR_HYST, 8'hFF);
		rd(fpm_pkg::ADDR_HYST, 8'h1F);
		wr(fpm_pkg::ADDR_HYST, 8'h04);
		set_temp(8'h1E);
		wr(fpm_pkg::ADDR_DUTY, 8'h15);
		rd(fpm_pkg::ADDR_DUTY, 8'h07);
		set_temp(8'h17);
		rd(fpm_pkg::ADDR_DUTY, 8'h07);
		wr(fpm_pkg::ADDR_HYST, 8'h02);
		set_temp(8'h16);
		rd(fpm_pkg::ADDR_DUTY, 8'h03);
		wr(fpm_pkg::ADDR_OFFS, 8'hFF);
		rd(fpm_pkg::ADDR_OFFS, 8'h3F);
		set_temp(8'h8B);
		rd(fpm_pkg::ADDR_DUTY, 8'h2F);
		spinup_active = 1'b1;
		rd(fpm_pkg::ADDR_DUTY, 8'h00);
		spinup_active = 1'b0;
		manual_override = 1'b1;
		rd(fpm_pkg::ADDR_DUTY, 8'h00);
		wr(fpm_pkg::ADDR_DUTY, 8'hFF);
		rd(fpm_pkg::ADDR_DUTY, 8'h3F);
		wr(fpm_pkg::ADDR_DUTY, 8'h20);
		rd(fpm_pkg::ADDR_DUTY, 8'h20);
		fan_case(5'h03, 1'b1);
		fan_case(5'h03, 1'b0);
		fan_case(5'h00, 1'b1);
		summarize();
	end
	initial begin
		#120000;
		bad_count++;
		summarize();
	end
endmodule : tb_top
`default_nettype wire

// >>> verilog/fpm_ctl_if.sv
// Internal carrier between the fan top module and its two helpers.
// Assumes all three modules share sys_clk.
`timescale 1ns/1ns
`default_nettype none
interface fpm_ctl_if;
	logic tick;
	logic [4:0] divisor;
	logic [5:0] duty;
	logic level;
	logic [7:0] temp;
	logic [5:0] offs;
	logic [4:0] hyst;
	logic [5:0] tbl_duty;
	modport top(output tick, divisor, duty, temp, offs, hyst, input level, tbl_duty);
	modport pwm(input tick, divisor, duty, output level);
	modport lut(input temp, offs, hyst, output tbl_duty);
endinterface : fpm_ctl_if
`default_nettype wire

// >>> verilog/fpm_lut.sv
// Table compare with offset and hysteresis, selecting the table duty.
// Assumes thresholds rise with entry index and share sys_clk with the top.
`timescale 1ns/1ns
`default_nettype none
module fpm_lut #(
	parameter int N = fpm_pkg::NUM_ENTRIES
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic nrst,
	// Control carrier
	fpm_ctl_if.lut ctl,
	// Table entries, entry 0 in the low bits
	input wire logic [N*7-1:0] thr_flat,
	input wire logic [N*6-1:0] duty_flat
);
	localparam int LW = $clog2(N + 1);
	logic [8:0] thr_sum [N];
	logic [5:0] duty_e [N];
	logic [N-1:0] above;
	logic [LW-1:0] level;
	logic [LW-1:0] next_level;
	logic [LW-1:0] target;
	logic [8:0] cur_thr;
	logic drop;
	logic [5:0] duty_q;
	logic [5:0] next_duty;

	////////////////////////////////////////////////////////////////////////////
	genvar i;
	generate
		for (i = 0; i < N; i++) begin : g_entry
			assign thr_sum[i] = 9'(thr_flat[i*7 +: 7]) + 9'(ctl.offs);
			assign above[i] = {1'b0, ctl.temp} > thr_sum[i];
			assign duty_e[i] = duty_flat[i*6 +: 6];
		end
	endgenerate

	assign cur_thr = (level == '0) ? 9'h000 : thr_sum[level - 1'b1];
	assign drop = (level != '0) && ({1'b0, ctl.temp} + 9'(ctl.hyst) < cur_thr);

	always_comb begin
		target = '0;
		for (int k = 0; k < N; k++) begin
			if (above[k]) begin
				target = LW'(k + 1);
			end
		end
		// up at once, down past band
		if (target > level || drop) begin
			next_level = target;
		end else begin
			next_level = level;
		end
		next_duty = (next_level == '0) ? 6'h00 : duty_e[next_level - 1'b1];
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			level <= '0;
			duty_q <= 6'h00;
		end else begin
			level <= next_level;
			duty_q <= next_duty;
		end
	end

	assign ctl.tbl_duty = duty_q;

	////////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!nrst);

	chk_step_up: assert property (target > level |=> level == $past(target))
		else $error("no immediate step up");
	chk_hold_band: assert property (target < level && !drop |=> level == $past(level))
		else $error("stepped down inside hysteresis band");
	chk_duty_pair: assert property (level != '0 |-> duty_q == duty_e[level - 1'b1])
		else $error("table duty not paired with entry");
endmodule : fpm_lut
`default_nettype wire

// >>> verilog/fpm_pkg.sv
// Constants shared by the fan duty and frequency block.
// Assumes a single 250 MHz system clock; all rates derive from it.
`default_nettype none
package fpm_pkg;
	////////////////////////////////////////////////////////////////////////////
	// Register offsets.
	localparam logic [7:0] ADDR_DUTY = 8'h4C;
	localparam logic [7:0] ADDR_FREQ = 8'h4D;
	localparam logic [7:0] ADDR_OFFS = 8'h4E;
	localparam logic [7:0] ADDR_HYST = 8'h4F;
	////////////////////////////////////////////////////////////////////////////
	// Field widths and positions.
	localparam int DUTY_W = 6;
	localparam int DIV_W = 5;
	localparam int OFFS_W = 6;
	localparam int HYST_W = 5;
	localparam int TEMP_W = 8;
	localparam int THR_W = 7;
	localparam int DUTY_SHIFT = 6;
	localparam int NUM_ENTRIES = 12;
	////////////////////////////////////////////////////////////////////////////
	// Reset values.
	localparam logic [5:0] DUTY_RST = 6'h00;
	localparam logic [4:0] FREQ_RST = 5'h17;
	localparam logic [5:0] OFFS_RST = 6'h00;
	localparam logic [4:0] HYST_RST = 5'h04;
	localparam logic [7:0] RDATA_RST = 8'h00;
	////////////////////////////////////////////////////////////////////////////
	// Master clock rates and the system-clock counts derived from them.
	localparam int SYS_CLK_HZ = 250_000_000;
	localparam int FAST_MCLK_HZ = 360_000;
	localparam int SLOW_MCLK_HZ = 1_400;
	localparam int FAST_DIV = SYS_CLK_HZ / FAST_MCLK_HZ;
	localparam int SLOW_DIV = SYS_CLK_HZ / SLOW_MCLK_HZ;
	localparam int MDIV_W = 18;
endpackage : fpm_pkg
`default_nettype wire

// >>> verilog/fpm_pwm.sv
// Fan output waveform generator, stepped by the master clock tick.
// Assumes tick is a one-cycle pulse on sys_clk.
`timescale 1ns/1ns
`default_nettype none
module fpm_pwm (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic nrst,
	// Control carrier
	fpm_ctl_if.pwm ctl
);
	logic [4:0] act_div;
	logic [4:0] next_div;
	logic [4:0] div_eff;
	logic [5:0] cnt;
	logic [5:0] next_cnt;
	logic [5:0] period;
	logic [5:0] high;
	logic [11:0] prod;
	logic last;
	logic out_q;
	logic next_out;

	////////////////////////////////////////////////////////////////////////////
	// zero maps to one
	assign div_eff = (ctl.divisor == 5'h00) ? 5'h01 : ctl.divisor;
	assign period = {act_div, 1'b0};
	assign last = (cnt >= period - 6'h01);
	assign prod = 12'(ctl.duty) * 12'(period);
	assign high = prod[11:6];

	always_comb begin
		next_cnt = cnt;
		next_div = act_div;
		next_out = (cnt < high);
		if (ctl.tick) begin
			if (last) begin
				next_cnt = 6'h00;
				next_div = div_eff;
			end else begin
				next_cnt = cnt + 6'h01;
			end
		end
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			cnt <= 6'h00;
			act_div <= fpm_pkg::FREQ_RST;
			out_q <= 1'b0;
		end else begin
			cnt <= next_cnt;
			act_div <= next_div;
			out_q <= next_out;
		end
	end

	assign ctl.level = out_q;

	////////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!nrst);

	chk_div_hold: assert property (ctl.tick && !last |=> act_div == $past(act_div))
		else $error("divisor changed inside a period");
	chk_period_wrap: assert property (ctl.tick && last |=> cnt == 6'h00 && act_div == $past(div_eff))
		else $error("period did not wrap with new divisor");
	chk_zero_map: assert property (ctl.tick && last && ctl.divisor == 5'h00 |=> act_div == 5'h01)
		else $error("divisor zero not mapped to one");
	chk_zero_duty: assert property (ctl.duty == 6'h00 |=> !ctl.level)
		else $error("output high at zero duty");
endmodule : fpm_pwm
`default_nettype wire

// >>> verilog/fpm_top.sv
// Fan duty, frequency, table offset and hysteresis registers with the fan output.
// Assumes register strobes, override, clock select and spin-up come from sys_clk logic.
//
// Overview of operation
// - Without override, duty register is read-only and returns the table duty.
// - With override, written duty is stored and drives the fan directly.
// - During spin-up the duty register reads zero.
// - Unused upper bits of frequency, offset and hysteresis registers read zero.
// - Master clock is 360 kHz or 1.4 kHz, picked by clock select.
// - Output frequency is master clock over twice the divisor.
// - A divisor of zero acts as one.
// - Offset is added to every table threshold, reaching above 127 degrees.
// - Offset is unsigned whole degrees, at most 63.
// - Hysteresis field sets the band used for table compares.
// - Hysteresis is one degree per step, at most 31.
// - Temperature above a threshold selects that entry's duty.
`timescale 1ns/1ns
`default_nettype none
module fpm_top #(
	parameter int N = fpm_pkg::NUM_ENTRIES,
	parameter int FAST_DIV = fpm_pkg::FAST_DIV,
	parameter int SLOW_DIV = fpm_pkg::SLOW_DIV
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic nrst,
	// Register port
	input wire logic [7:0] reg_addr,
	input wire logic reg_wr,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	// Controls from the fan configuration logic
	input wire logic manual_override,
	input wire logic clk_select,
	input wire logic spinup_active,
	// Remote temperature in whole degrees
	input wire logic [7:0] remote_temp,
	// Table entries
	input wire logic [N*7-1:0] thr_flat,
	input wire logic [N*6-1:0] duty_flat,
	// Fan drive
	output logic fan_pwm
);
	fpm_ctl_if ctl ();

	logic [5:0] man_duty;
	logic [5:0] next_man_duty;
	logic [4:0] freq_div;
	logic [4:0] next_freq_div;
	logic [5:0] tbl_offs;
	logic [5:0] next_tbl_offs;
	logic [4:0] tbl_hyst;
	logic [4:0] next_tbl_hyst;
	logic [7:0] next_rdata;
	logic [fpm_pkg::MDIV_W-1:0] mdiv_cnt;
	logic [fpm_pkg::MDIV_W-1:0] next_mdiv_cnt;
	logic [fpm_pkg::MDIV_W-1:0] mdiv_lim;
	logic tick_q;
	logic next_tick;
	logic wr_duty;
	logic [fpm_pkg::MDIV_W-1:0] gap_cnt;
	logic [fpm_pkg::MDIV_W-1:0] next_gap_cnt;
	logic sel_seen;
	logic next_sel_seen;
	logic sel_moved;
	logic next_sel_moved;
	localparam logic [fpm_pkg::MDIV_W-1:0] FAST_GAP = fpm_pkg::MDIV_W'(FAST_DIV);
	localparam logic [fpm_pkg::MDIV_W-1:0] SLOW_GAP = fpm_pkg::MDIV_W'(SLOW_DIV);

	////////////////////////////////////////////////////////////////////////////
	// Register writes.
	assign wr_duty = reg_wr && (reg_addr == fpm_pkg::ADDR_DUTY);

	always_comb begin
		next_man_duty = man_duty;
		next_freq_div = freq_div;
		next_tbl_offs = tbl_offs;
		next_tbl_hyst = tbl_hyst;
		if (wr_duty && manual_override) begin
			next_man_duty = reg_wdata[5:0];
		end
		if (reg_wr && reg_addr == fpm_pkg::ADDR_FREQ) begin
			next_freq_div = reg_wdata[4:0];
		end
		if (reg_wr && reg_addr == fpm_pkg::ADDR_OFFS) begin
			next_tbl_offs = reg_wdata[5:0];
		end
		if (reg_wr && reg_addr == fpm_pkg::ADDR_HYST) begin
			next_tbl_hyst = reg_wdata[4:0];
		end
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			man_duty <= fpm_pkg::DUTY_RST;
			freq_div <= fpm_pkg::FREQ_RST;
			tbl_offs <= fpm_pkg::OFFS_RST;
			tbl_hyst <= fpm_pkg::HYST_RST;
		end else begin
			man_duty <= next_man_duty;
			freq_div <= next_freq_div;
			tbl_offs <= next_tbl_offs;
			tbl_hyst <= next_tbl_hyst;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Register reads, one cycle after the address.
	always_comb begin
		next_rdata = 8'h00;
		unique case (reg_addr)
			fpm_pkg::ADDR_DUTY: begin
				if (spinup_active) begin
					next_rdata = 8'h00;
				end else if (manual_override) begin
					next_rdata = {2'b00, man_duty};
				end else begin
					next_rdata = {2'b00, ctl.tbl_duty};
				end
			end
			fpm_pkg::ADDR_FREQ: next_rdata = {3'b000, freq_div};
			fpm_pkg::ADDR_OFFS: next_rdata = {2'b00, tbl_offs};
			fpm_pkg::ADDR_HYST: next_rdata = {3'b000, tbl_hyst};
			default: next_rdata = 8'h00;
		endcase
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			reg_rdata <= fpm_pkg::RDATA_RST;
		end else begin
			reg_rdata <= next_rdata;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Master clock tick. The counter compares with >= so that a select change
	// mid-count cannot leave it stranded above the new limit.
	// pick master clock rate
	assign mdiv_lim = clk_select ? fpm_pkg::MDIV_W'(FAST_DIV - 1)
		: fpm_pkg::MDIV_W'(SLOW_DIV - 1);

	always_comb begin
		next_tick = 1'b0;
		next_mdiv_cnt = mdiv_cnt + 1'b1;
		if (mdiv_cnt >= mdiv_lim) begin
			next_mdiv_cnt = '0;
			next_tick = 1'b1;
		end
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			mdiv_cnt <= '0;
			tick_q <= 1'b0;
		end else begin
			mdiv_cnt <= next_mdiv_cnt;
			tick_q <= next_tick;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Tick spacing watch for the checks. A select change between two ticks
	// leaves one odd gap, so that gap is flagged and not judged.
	always_comb begin
		next_gap_cnt = gap_cnt + 1'b1;
		next_sel_seen = clk_select;
		next_sel_moved = sel_moved || (clk_select != sel_seen);
		if (tick_q) begin
			next_gap_cnt = fpm_pkg::MDIV_W'(1);
			next_sel_moved = 1'b0;
		end
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			gap_cnt <= '0;
			sel_seen <= 1'b0;
			sel_moved <= 1'b0;
		end else begin
			gap_cnt <= next_gap_cnt;
			sel_seen <= next_sel_seen;
			sel_moved <= next_sel_moved;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Helpers.
	assign ctl.tick = tick_q;
	assign ctl.divisor = freq_div;
	assign ctl.duty = manual_override ? man_duty : ctl.tbl_duty;
	assign ctl.temp = remote_temp;
	assign ctl.offs = tbl_offs;
	assign ctl.hyst = tbl_hyst;
	assign fan_pwm = ctl.level;

	fpm_pwm u_pwm (
		.sys_clk(sys_clk),
		.nrst(nrst),
		.ctl(ctl.pwm)
	);

	fpm_lut #(
		.N(N)
	) u_lut (
		.sys_clk(sys_clk),
		.nrst(nrst),
		.ctl(ctl.lut),
		.thr_flat(thr_flat),
		.duty_flat(duty_flat)
	);

	////////////////////////////////////////////////////////////////////////////
	// Checks.
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!nrst);

	chk_duty_ro: assert property (
		wr_duty && !manual_override |=> man_duty == $past(man_duty))
		else $error("duty written without override");

	chk_duty_tbl_read: assert property (
		reg_addr == fpm_pkg::ADDR_DUTY && !spinup_active && !manual_override
		|=> reg_rdata == {2'b00, $past(ctl.tbl_duty)})
		else $error("duty read does not show table value");

	chk_duty_rsvd: assert property (
		reg_addr == fpm_pkg::ADDR_DUTY |=> reg_rdata[7:6] == 2'b00)
		else $error("duty upper bits not zero");

	chk_man_write: assert property (
		wr_duty && manual_override && !spinup_active
		##1 reg_addr == fpm_pkg::ADDR_DUTY && manual_override && !spinup_active
		|=> reg_rdata == {2'b00, $past(reg_wdata[5:0], 2)})
		else $error("manual duty not read back");

	chk_man_keep: assert property (
		!wr_duty |=> man_duty == $past(man_duty))
		else $error("manual duty changed without a write");

	chk_spinup_zero: assert property (
		spinup_active && reg_addr == fpm_pkg::ADDR_DUTY |=> reg_rdata == 8'h00)
		else $error("duty nonzero during spin-up");

	chk_rsvd_zero: assert property (
		reg_addr == fpm_pkg::ADDR_FREQ || reg_addr == fpm_pkg::ADDR_HYST
		|=> reg_rdata[7:5] == 3'b000)
		else $error("reserved bits not zero");

	chk_offs_rsvd: assert property (
		reg_addr == fpm_pkg::ADDR_OFFS |=> reg_rdata[7:6] == 2'b00)
		else $error("offset reserved bits not zero");

	chk_unmapped_zero: assert property (
		reg_addr < fpm_pkg::ADDR_DUTY || reg_addr > fpm_pkg::ADDR_HYST
		|=> reg_rdata == 8'h00)
		else $error("unmapped address read nonzero");

	chk_tick_gap: assert property (tick_q |=> !tick_q [*8])
		else $error("master ticks too close");

	chk_tick_rate: assert property (
		tick_q && !sel_moved |-> gap_cnt == (clk_select ? FAST_GAP : SLOW_GAP))
		else $error("master tick spacing wrong for the selected rate");

	chk_freq_write: assert property (
		reg_wr && reg_addr == fpm_pkg::ADDR_FREQ |=> freq_div == $past(reg_wdata[4:0]))
		else $error("frequency divisor not stored");

	chk_offs_write: assert property (
		reg_wr && reg_addr == fpm_pkg::ADDR_OFFS |=> tbl_offs == $past(reg_wdata[5:0]))
		else $error("table offset not stored");

	chk_hyst_write: assert property (
		reg_wr && reg_addr == fpm_pkg::ADDR_HYST |=> tbl_hyst == $past(reg_wdata[4:0]))
		else $error("table hysteresis not stored");

	// Main scenarios, for coverage only.
	cov_override_write: cover property (wr_duty && manual_override);
	cov_spinup_read: cover property (spinup_active && reg_addr == fpm_pkg::ADDR_DUTY);
	cov_fast_tick: cover property (tick_q && clk_select);
	cov_slow_tick: cover property (tick_q && !clk_select);
	cov_fan_rise: cover property (!fan_pwm ##1 fan_pwm);
endmodule : fpm_top
`default_nettype wire
